// ===== design/see_defs.vh
// constants for the secure exception entry block: status word fields,
// mode codes, vector offsets and configuration bit positions.
// assumes a 32-bit status word laid out as the core's program status.
//
// Overview of operation
// - monitor call raises its own exception
// - config bits 1..3 route irq, fiq, abort
// - base chosen by world and monitor mode
// - per-world bit 13 forces base 0xFFFF0000 except on monitor-bound entries
// - reset clears world bit, enters supervisor
// - reset masks all, loads secure endian, compact
// - reset starts at high or zero vector
// - undefined: undef mode, link, save, base+4
// - software trap: supervisor mode, base+8
// - secure entries other than reset and monitor-bound use secure base register
// - entry from monitor forces secure world
// - trapped prefetch abort enters monitor, base+0xC
// - untrapped prefetch abort enters abort mode
// - non-secure abort masks imprecise only if bit5
// - secure abort always masks imprecise aborts
// - same-world entry loads compact bit 30
// - same-world entry loads endian bit 25
// - monitor mode always runs as secure
`ifndef SEE_DEFS_VH
`define SEE_DEFS_VH

// ---------------------------------------------------------------
// status word fields
// ---------------------------------------------------------------
`define SEE_MODE_HI      4
`define SEE_MODE_LO      0
`define SEE_T_BIT        5
`define SEE_F_BIT        6
`define SEE_I_BIT        7
`define SEE_A_BIT        8
`define SEE_E_BIT        9
`define SEE_J_BIT        24

// ---------------------------------------------------------------
// mode codes
// ---------------------------------------------------------------
`define SEE_MODE_SVC     5'h13
`define SEE_MODE_UND     5'h1b
`define SEE_MODE_ABT     5'h17
`define SEE_MODE_MON     5'h16

// ---------------------------------------------------------------
// configuration and control bit positions
// ---------------------------------------------------------------
`define SEE_CFG_NS       0
`define SEE_CFG_RT_HI    3
`define SEE_CFG_RT_LO    1
`define SEE_CFG_EA       3
`define SEE_CFG_AW       5
`define SEE_CTL_HIVEC    13
`define SEE_CTL_EE       25
`define SEE_CTL_TE       30

// ---------------------------------------------------------------
// vectors and offsets
// ---------------------------------------------------------------
`define SEE_HIGH_BASE    32'hffff_0000
`define SEE_LOW_BASE     32'h0000_0000
`define SEE_OFS_UND      32'h0000_0004
`define SEE_OFS_SWT      32'h0000_0008
`define SEE_OFS_PABT     32'h0000_000c
`define SEE_OFS_SMC      32'h0000_0008
`define SEE_ABT_LINK_ADJ 32'h0000_0004
`define SEE_RESET_PSR    32'h0000_01d3

`endif

// ===== design/see_vec_sel.v
// vector base selection for the secure exception entry block.
// assumes base registers and control words are stable inputs.
`timescale 1ns/1ps
`default_nettype none
`include "see_defs.vh"

module see_vec_sel #(
  parameter WIDTH = 32
) (
  input  wire             clk_in,
  input  wire             rst_n_in,
  input  wire             to_monitor_in,
  input  wire             secure_in,
  input  wire [WIDTH-1:0] nsec_base_in,
  input  wire [WIDTH-1:0] sec_base_in,
  input  wire [WIDTH-1:0] mon_base_in,
  input  wire             nsec_hivec_in,
  input  wire             sec_hivec_in,
  input  wire [WIDTH-1:0] offset_in,
  output reg  [WIDTH-1:0] vector_out
);

  // ---------------------------------------------------------------
  // base pick, registered
  // ---------------------------------------------------------------
  reg [WIDTH-1:0] base;

  // monitor base, else per-world base with high-vector override
  always @* begin
    if (to_monitor_in) begin
      base = mon_base_in;
    end else if (secure_in) begin
      base = sec_hivec_in ? `SEE_HIGH_BASE : sec_base_in;
    end else begin
      base = nsec_hivec_in ? `SEE_HIGH_BASE : nsec_base_in;
    end
  end

  // vector registered so it lands with the rest of the entry
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      vector_out <= `SEE_LOW_BASE;
    end else begin
      vector_out <= base + offset_in;
    end
  end

endmodule // see_vec_sel
`default_nettype wire

// ===== design/see_entry.v
// secure exception entry: reset, undefined instruction, software trap,
// monitor call and external prefetch abort.
// assumes at most one request pulse per cycle from the pipeline, which
// holds off fetch until entry_done_out pulses.
`timescale 1ns/1ps
`default_nettype none
`include "see_defs.vh"

module see_entry #(
  parameter WIDTH          = 32,
  parameter COMPACT_EXISTS = 1
) (
  input  wire             clk_in,
  input  wire             rst_n_in,
  input  wire             undef_req_in,
  input  wire             soft_trap_req_in,
  input  wire             secure_monitor_call_in,
  input  wire             ext_pabt_req_in,
  input  wire [WIDTH-1:0] next_addr_in,
  input  wire [WIDTH-1:0] status_wr_in,
  input  wire             status_wr_en_in,
  input  wire [WIDTH-1:0] secure_config_reg_in,
  input  wire [WIDTH-1:0] nsec_control_in,
  input  wire [WIDTH-1:0] sec_control_in,
  input  wire [WIDTH-1:0] vector_base_reg_ns_in,
  input  wire [WIDTH-1:0] vector_base_reg_s_in,
  input  wire [WIDTH-1:0] monitor_vector_base_reg_in,
  output reg  [WIDTH-1:0] current_status_word_out,
  output reg              world_select_bit_out,
  output reg              secure_out,
  output reg  [WIDTH-1:0] saved_status_word_out,
  output reg  [WIDTH-1:0] link_addr_out,
  output reg  [3:0]       link_sel_out,
  output reg              entry_done_out,
  output wire [WIDTH-1:0] pc_out,
  output reg  [2:0]       route_out,
  output reg              monitor_call_taken_out
);

  // ---------------------------------------------------------------
  // operation outline
  // ---------------------------------------------------------------
  // the pipeline raises one request pulse beside the next address
  // and holds fetch until entry_done_out; every field of an entry is
  // written on one edge, so the handler never sees half an entry.
  // priority when requests meet in one cycle: monitor call, prefetch
  // abort, software trap, undefined; the losers are dropped.
  // the reset entry takes the first cycle after reset release and
  // ignores requests; callers start in the cycle after its pulse.
  // pipeline status writes are dropped in a cycle with an entry.
  // world handling:
  //   the stored world bit follows configuration bit 0 between
  //   entries, so software owns it through the configuration input.
  //   an entry taken from monitor mode forces it secure for that
  //   entry only; software must clear bit 0 itself to stay secure.
  //   monitor mode always counts as secure, whatever the stored bit.
  // vector base:
  //   monitor-bound entries use the monitor base, with no high-vector
  //   override; others use the base of the current world, or the
  //   high base when that world's high-vector bit is set.
  //   the reset entry looks only at the secure high-vector bit.
  // masks:
  //   every entry sets the interrupt mask; monitor-bound entries set
  //   all three; an abort-mode entry sets the imprecise-abort mask
  //   from secure state always, from non-secure only when allowed.
  // status bits:
  //   endian and compact bits come from the current world's controls,
  //   or from the secure ones for monitor-bound and reset entries.

  // ---------------------------------------------------------------
  // link register selects (one-hot)
  // ---------------------------------------------------------------
  localparam [3:0] LINK_SVC = 4'h1;
  localparam [3:0] LINK_UND = 4'h2;
  localparam [3:0] LINK_ABT = 4'h4;
  localparam [3:0] LINK_MON = 4'h8;

  // ---------------------------------------------------------------
  // states, one-hot
  // ---------------------------------------------------------------
  localparam [1:0] ST_RESET = 2'h1;
  localparam [1:0] ST_RUN   = 2'h2;

  reg [1:0]       state_reg;
  reg [1:0]       state_next;
  reg [WIDTH-1:0] psr_next;
  reg             ns_next;
  reg [WIDTH-1:0] saved_status_word_next;
  reg [WIDTH-1:0] link_next;
  reg [3:0]       sel_next;
  reg             done_next;
  reg             to_mon;
  reg [WIDTH-1:0] offset;
  reg             call_next;

  wire in_monitor;
  wire cur_secure;
  wire any_req;
  wire [WIDTH-1:0] cur_ctl;
  wire vec_secure;
  wire [WIDTH-1:0] vec_sec_base;

  // monitor mode always counts as secure, whatever the stored bit
  function is_monitor;
    input [WIDTH-1:0] psr;
    begin
      is_monitor = (psr[`SEE_MODE_HI:`SEE_MODE_LO] == `SEE_MODE_MON);
    end
  endfunction

  assign in_monitor = is_monitor(current_status_word_out);
  assign cur_secure = in_monitor | ~world_select_bit_out;
  assign cur_ctl    = cur_secure ? sec_control_in : nsec_control_in;
  assign any_req    = undef_req_in | soft_trap_req_in
                    | secure_monitor_call_in | ext_pabt_req_in;

  // reset entry always looks at the secure bank with a zero base
  assign vec_secure   = (state_reg == ST_RESET) | cur_secure;
  assign vec_sec_base = (state_reg == ST_RESET) ? `SEE_LOW_BASE
                                                : vector_base_reg_s_in;

  // ---------------------------------------------------------------
  // vector base pick
  // ---------------------------------------------------------------
  see_vec_sel #(
    .WIDTH (WIDTH)
  ) u_vec (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .to_monitor_in (to_mon),
    .secure_in     (vec_secure),
    .nsec_base_in  (vector_base_reg_ns_in),
    .sec_base_in   (vec_sec_base),
    .mon_base_in   (monitor_vector_base_reg_in),
    .nsec_hivec_in (nsec_control_in[`SEE_CTL_HIVEC]),
    .sec_hivec_in  (sec_control_in[`SEE_CTL_HIVEC]),
    .offset_in     (offset),
    .vector_out    (pc_out)
  );

  // ---------------------------------------------------------------
  // entry decode: next status, link, saved status, world
  // ---------------------------------------------------------------
  always @* begin
    state_next = ST_RUN;
    psr_next   = current_status_word_out;
    ns_next    = world_select_bit_out;
    saved_status_word_next  = saved_status_word_out;
    link_next  = link_addr_out;
    sel_next   = 4'h0;
    done_next  = 1'b0;
    to_mon     = 1'b0;
    offset     = `SEE_LOW_BASE;
    call_next  = 1'b0;
    case (state_reg)
      ST_RESET: begin
        // first cycle after reset release: secure supervisor entry
        ns_next  = 1'b0;
        psr_next = `SEE_RESET_PSR;
        psr_next[`SEE_E_BIT] = sec_control_in[`SEE_CTL_EE];
        psr_next[`SEE_T_BIT] = (COMPACT_EXISTS != 0)
                             & sec_control_in[`SEE_CTL_TE];
        offset    = `SEE_LOW_BASE;
        done_next = 1'b1;
      end
      ST_RUN: begin
        // stored world bit follows the configuration between entries
        ns_next = secure_config_reg_in[`SEE_CFG_NS];
        if (status_wr_en_in && !any_req) begin
          psr_next = status_wr_in;
        end
        if (any_req) begin
          saved_status_word_next = current_status_word_out;
          done_next = 1'b1;
          if (in_monitor) begin
            ns_next = 1'b0;
          end
          // same-world defaults
          psr_next[`SEE_I_BIT] = 1'b1;
          psr_next[`SEE_J_BIT] = 1'b0;
          psr_next[`SEE_E_BIT] = cur_ctl[`SEE_CTL_EE];
          psr_next[`SEE_T_BIT] = (COMPACT_EXISTS != 0)
                               & cur_ctl[`SEE_CTL_TE];
          if (secure_monitor_call_in) begin
            // monitor call: its own exception into monitor mode
            call_next = 1'b1;
            to_mon    = 1'b1;
            link_next = next_addr_in;
            sel_next  = LINK_MON;
            psr_next[`SEE_MODE_HI:`SEE_MODE_LO] = `SEE_MODE_MON;
            psr_next[`SEE_F_BIT] = 1'b1;
            psr_next[`SEE_A_BIT] = 1'b1;
            psr_next[`SEE_E_BIT] = sec_control_in[`SEE_CTL_EE];
            psr_next[`SEE_T_BIT] = (COMPACT_EXISTS != 0)
                                 & sec_control_in[`SEE_CTL_TE];
            ns_next   = 1'b0;
            offset    = `SEE_OFS_SMC;
          end else if (ext_pabt_req_in) begin
            link_next = next_addr_in + `SEE_ABT_LINK_ADJ;
            if (secure_config_reg_in[`SEE_CFG_EA]) begin
              to_mon   = 1'b1;
              sel_next = LINK_MON;
              psr_next[`SEE_MODE_HI:`SEE_MODE_LO] = `SEE_MODE_MON;
              psr_next[`SEE_F_BIT] = 1'b1;
              psr_next[`SEE_A_BIT] = 1'b1;
              psr_next[`SEE_E_BIT] = sec_control_in[`SEE_CTL_EE];
              psr_next[`SEE_T_BIT] = (COMPACT_EXISTS != 0)
                                   & sec_control_in[`SEE_CTL_TE];
            end else begin
              sel_next = LINK_ABT;
              psr_next[`SEE_MODE_HI:`SEE_MODE_LO] = `SEE_MODE_ABT;
              if (cur_secure) begin
                psr_next[`SEE_A_BIT] = 1'b1;
              end else if (secure_config_reg_in[`SEE_CFG_AW]) begin
                psr_next[`SEE_A_BIT] = 1'b1;
              end
            end
            offset = `SEE_OFS_PABT;
          end else if (soft_trap_req_in) begin
            link_next = next_addr_in;
            sel_next  = LINK_SVC;
            psr_next[`SEE_MODE_HI:`SEE_MODE_LO] = `SEE_MODE_SVC;
            offset    = `SEE_OFS_SWT;
          end else begin
            link_next = next_addr_in;
            sel_next  = LINK_UND;
            psr_next[`SEE_MODE_HI:`SEE_MODE_LO] = `SEE_MODE_UND;
            offset    = `SEE_OFS_UND;
          end
        end
      end
      default: begin
        state_next = ST_RESET;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // state update: every field of one entry in the same edge
  // ---------------------------------------------------------------
  // reset entry first, then run
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_reg <= ST_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // status word, written by entries and by the pipeline
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      current_status_word_out <= `SEE_RESET_PSR;
    end else begin
      current_status_word_out <= psr_next;
    end
  end

  // stored world bit
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      world_select_bit_out <= 1'b0;
    end else begin
      world_select_bit_out <= ns_next;
    end
  end

  // effective secure state, monitor mode counts as secure
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      secure_out <= 1'b1;
    end else begin
      secure_out <= ~ns_next | is_monitor(psr_next);
    end
  end

  // saved status copy
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      saved_status_word_out <= `SEE_LOW_BASE;
    end else begin
      saved_status_word_out <= saved_status_word_next;
    end
  end

  // link value for the selected mode
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      link_addr_out <= `SEE_LOW_BASE;
    end else begin
      link_addr_out <= link_next;
    end
  end

  // link target select, one cycle
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      link_sel_out <= 4'h0;
    end else begin
      link_sel_out <= sel_next;
    end
  end

  // entry complete pulse
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      entry_done_out <= 1'b0;
    end else begin
      entry_done_out <= done_next;
    end
  end

  // monitor call taken pulse
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      monitor_call_taken_out <= 1'b0;
    end else begin
      monitor_call_taken_out <= call_next;
    end
  end

  // routing copy of the configuration bits
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      route_out <= 3'h0;
    end else begin
      route_out <= secure_config_reg_in[`SEE_CFG_RT_HI:`SEE_CFG_RT_LO];
    end
  end

endmodule // see_entry
`default_nettype wire

// ===== tb/see_entry_properties.sv
// checker for see_entry: entry outcome against request and configuration.
// assumes it is bound to see_entry and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
`include "see_defs.vh"
module see_entry_properties #(
  parameter WIDTH = 32
) (
  input wire logic             clk_in,
  input wire logic             rst_n_in,
  input wire logic             undef_req_in,
  input wire logic             soft_trap_req_in,
  input wire logic             secure_monitor_call_in,
  input wire logic             ext_pabt_req_in,
  input wire logic [WIDTH-1:0] next_addr_in,
  input wire logic [WIDTH-1:0] secure_config_reg_in,
  input wire logic [WIDTH-1:0] monitor_vector_base_reg_in,
  input wire logic [WIDTH-1:0] current_status_word_out,
  input wire logic             world_select_bit_out,
  input wire logic             secure_out,
  input wire logic [WIDTH-1:0] saved_status_word_out,
  input wire logic [WIDTH-1:0] link_addr_out,
  input wire logic [3:0]       link_sel_out,
  input wire logic             entry_done_out,
  input wire logic [WIDTH-1:0] pc_out,
  input wire logic             monitor_call_taken_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // ----------------------------------------
  // winning request after priority
  // ----------------------------------------
  sequence s_pabt;
    ext_pabt_req_in && !secure_monitor_call_in;
  endsequence
  sequence s_swt;
    soft_trap_req_in && !secure_monitor_call_in && !ext_pabt_req_in;
  endsequence
  sequence s_und;
    undef_req_in && !secure_monitor_call_in && !ext_pabt_req_in && !soft_trap_req_in;
  endsequence
  // ----------------------------------------
  // entry properties
  // ----------------------------------------
  property p_done;
    (undef_req_in || soft_trap_req_in || secure_monitor_call_in || ext_pabt_req_in)
      |=> entry_done_out && saved_status_word_out == $past(current_status_word_out);
  endproperty
  a_done: assert property (p_done) else $error("entry not complete in one cycle");
  property p_smc;
    secure_monitor_call_in |=> monitor_call_taken_out && current_status_word_out[4:0] ==
      `SEE_MODE_MON && pc_out == $past(monitor_vector_base_reg_in) + `SEE_OFS_SMC;
  endproperty
  a_smc: assert property (p_smc) else $error("monitor call entry wrong");
  property p_und;
    s_und |=> current_status_word_out[4:0] == `SEE_MODE_UND && link_sel_out == 4'h2 &&
      link_addr_out == $past(next_addr_in) && current_status_word_out[`SEE_I_BIT];
  endproperty
  a_und: assert property (p_und) else $error("undefined entry wrong");
  property p_swt;
    s_swt |=> current_status_word_out[4:0] == `SEE_MODE_SVC && link_sel_out == 4'h1 &&
      link_addr_out == $past(next_addr_in);
  endproperty
  a_swt: assert property (p_swt) else $error("software trap entry wrong");
  property p_pabt_mon;
    s_pabt ##0 secure_config_reg_in[3] |=> current_status_word_out[4:0] == `SEE_MODE_MON &&
      link_sel_out == 4'h8 && link_addr_out == $past(next_addr_in) + 32'h0000_0004 &&
      current_status_word_out[8:6] == 3'b111 &&
      pc_out == $past(monitor_vector_base_reg_in) + `SEE_OFS_PABT;
  endproperty
  a_pabt_mon: assert property (p_pabt_mon) else $error("trapped abort entry wrong");
  property p_pabt_abt;
    s_pabt ##0 !secure_config_reg_in[3] |=> current_status_word_out[4:0] == `SEE_MODE_ABT &&
      link_sel_out == 4'h4 && current_status_word_out[`SEE_I_BIT];
  endproperty
  a_pabt_abt: assert property (p_pabt_abt) else $error("abort mode entry wrong");
  property p_ns_amask;
    s_pabt ##0 (!secure_config_reg_in[3] && !secure_config_reg_in[5] && !secure_out)
      |=> $stable(current_status_word_out[`SEE_A_BIT]);
  endproperty
  a_ns_amask: assert property (p_ns_amask) else $error("abort mask changed");
  property p_mon_sec;
    current_status_word_out[4:0] == `SEE_MODE_MON |-> secure_out;
  endproperty
  a_mon_sec: assert property (p_mon_sec) else $error("monitor mode not secure");
  property p_reset;
    $rose(rst_n_in) |-> ##[1:2] (entry_done_out && !world_select_bit_out &&
      current_status_word_out[4:0] == `SEE_MODE_SVC && current_status_word_out[8:6] == 3'b111);
  endproperty
  a_reset: assert property (p_reset) else $error("reset entry wrong");
endmodule // see_entry_properties
bind see_entry see_entry_properties #(.WIDTH(WIDTH)) i_see_entry_properties (
  .clk_in, .rst_n_in, .undef_req_in, .soft_trap_req_in, .secure_monitor_call_in,
  .ext_pabt_req_in, .next_addr_in, .secure_config_reg_in, .monitor_vector_base_reg_in,
  .current_status_word_out, .world_select_bit_out, .secure_out, .saved_status_word_out,
  .link_addr_out, .link_sel_out, .entry_done_out, .pc_out, .monitor_call_taken_out);
`default_nettype wire

// ===== tb/see_pipe_model.sv
// pipeline model: launches exception request pulses with the next address.
// assumes requests start only after the reset entry has completed.
`timescale 1ns/1ps
`default_nettype none
module see_pipe_model (
  input  wire logic        clk_in,
  output var  logic [3:0]  req_out,      // monitor call, abort, trap, undefined
  output var  logic [31:0] next_addr_out
);
  initial begin
    req_out = 4'h0;
    next_addr_out = 32'h0000_0000;
  end
  // one-cycle pulse; the address is scrambled afterwards, never left stale
  task automatic fire(input logic [3:0] kinds, input logic [31:0] addr);
    @(posedge clk_in);
    req_out <= kinds;
    next_addr_out <= addr;
    @(posedge clk_in);
    req_out <= 4'h0;
    next_addr_out <= ~addr;
  endtask
endmodule // see_pipe_model
`default_nettype wire

// ===== tb/test_see_entry.sv
// testbench for see_entry: reset, trap, abort and monitor call entries.
// assumes see_pipe_model as request source and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module test_see_entry;
  logic        clk_in = 1'b0, rst_n_in = 1'b0, wr_en = 1'b0;
  logic [31:0] cfg = 32'h0000_0000, st_wr = 32'h0000_0000;
  logic [31:0] ns_ctl = 32'h0200_0000, s_ctl = 32'h4000_2000;
  logic [31:0] ns_b = 32'h0000_1000, s_b = 32'h0000_2000, m_b = 32'h0000_3000;
  logic [31:0] nxt, st, saved, link, pc;
  logic [3:0]  req, lsel;
  logic [2:0]  route;
  logic        world, sec, done, smc_tk;
  int          n_errors = 0, cmp_count = 0, cycles = 0;
  always #4 clk_in = ~clk_in;
  see_pipe_model i_see_pipe_model (.clk_in(clk_in), .req_out(req), .next_addr_out(nxt));
  see_entry i_see_entry (.clk_in(clk_in), .rst_n_in(rst_n_in), .undef_req_in(req[0]),
    .soft_trap_req_in(req[1]), .secure_monitor_call_in(req[3]), .ext_pabt_req_in(req[2]),
    .next_addr_in(nxt), .status_wr_in(st_wr), .status_wr_en_in(wr_en),
    .secure_config_reg_in(cfg), .nsec_control_in(ns_ctl), .sec_control_in(s_ctl),
    .vector_base_reg_ns_in(ns_b), .vector_base_reg_s_in(s_b), .monitor_vector_base_reg_in(m_b),
    .current_status_word_out(st), .world_select_bit_out(world), .secure_out(sec),
    .saved_status_word_out(saved), .link_addr_out(link), .link_sel_out(lsel),
    .entry_done_out(done), .pc_out(pc), .route_out(route), .monitor_call_taken_out(smc_tk));
  // ----------------------------------------
  // compare, access and closing tasks
  // ----------------------------------------
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task end_sim;
    $display("compares %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task wait_done;
    #1;
    for (int i = 0; i < 4 && done !== 1'b1; i++) @(posedge clk_in) #1;
    chk("entry_done", 32'h1, {31'h0, done});
  endtask
  task do_reset;
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    wait_done;
  endtask
  task set_st(input logic [31:0] v);
    @(posedge clk_in);
    st_wr <= v;
    wr_en <= 1'b1;
    @(posedge clk_in);
    wr_en <= 1'b0;
  endtask
  // one entry, then mode, masks, endian, compact, pc and link checked
  task entry(input logic [3:0] k, input logic [31:0] a, input logic [4:0] m,
             input logic [3:0] fiaet, input logic [31:0] epc, input logic [31:0] elink);
    i_see_pipe_model.fire(k, a);
    wait_done;
    chk("mode", {27'h0, m}, {27'h0, st[4:0]});
    chk("f i a e t", {28'h0, fiaet}, {28'h0, st[6], st[8], st[9], st[5]} | {31'h0, st[7]^1'b1});
    chk("pc", epc, pc);
    chk("link", elink, link);
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      end_sim;
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    do_reset;
    chk("reset pc", 32'hffff_0000, pc);
    chk("reset psr", 32'h0000_01f3, st & 32'h0100_03ff);
    cfg <= 32'h0000_0001;
    s_ctl <= 32'h4000_0000;
    do_reset;
    chk("reset pc", 32'h0, pc);
    chk("world", 32'h0, {31'h0, world});
    set_st(32'h0000_0010);
    entry(4'h1, 32'h0000_0100, 5'h1b, 4'h2, 32'h0000_1004, 32'h0000_0100);
    chk("saved", 32'h0000_0010, saved);
    chk("world", 32'h1, {31'h0, world});
    chk("secure", 32'h0, {31'h0, sec});
    ns_ctl <= 32'h0200_2000;
    set_st(32'h0000_0010);
    entry(4'h2, 32'h0000_0200, 5'h13, 4'h2, 32'hffff_0008, 32'h0000_0200);
    cfg <= 32'h0000_0000;
    set_st(32'h0000_0010);
    entry(4'h2, 32'h0000_0240, 5'h13, 4'h1, 32'h0000_2008, 32'h0000_0240);
    ns_ctl <= 32'h0200_0000;
    cfg <= 32'h0000_0001;
    set_st(32'h0000_0010);
    entry(4'h4, 32'h0000_0300, 5'h17, 4'h2, 32'h0000_100c, 32'h0000_0304);
    cfg <= 32'h0000_0021;
    set_st(32'h0000_0010);
    entry(4'h4, 32'h0000_0340, 5'h17, 4'h6, 32'h0000_100c, 32'h0000_0344);
    cfg <= 32'h0000_0000;
    set_st(32'h0000_0010);
    entry(4'h4, 32'h0000_0380, 5'h17, 4'h5, 32'h0000_200c, 32'h0000_0384);
    cfg <= 32'h0000_0009;
    set_st(32'h0000_0010);
    entry(4'h4, 32'h0000_0400, 5'h16, 4'hd, 32'h0000_300c, 32'h0000_0404);
    chk("secure", 32'h1, {31'h0, sec});
    chk("route", 32'h0000_0004, {29'h0, route});
    entry(4'h1, 32'h0000_0500, 5'h1b, 4'hd, 32'h0000_2004, 32'h0000_0500);
    chk("world", 32'h0, {31'h0, world});
    entry(4'h9, 32'h0000_0600, 5'h16, 4'hd, 32'h0000_3008, 32'h0000_0600);
    chk("monitor call", 32'h1, {31'h0, smc_tk});
    end_sim;
  end
endmodule // test_see_entry
`default_nettype wire
